// >>> logic/vss_device.sv
// Purpose: sink code sequencer with one step, linear, two step and enhanced moves
// Assumes: link pairs arrive synchronous to ref_clk_i
// Notes: step timing from a half microsecond and a ten microsecond tick
`timescale 1ns/1ps
`include "vss_params.svh"

module vss_device
  import vss_pkg::*;
#(
  parameter int TICK_X2_CYCLES = `VSS_TICK_X2_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  vss_link_if.dev link,
  output logic [9:0] sink_code_o,
  output logic [16:0] sink_current_ua_o,
  output logic busy_o
);

  localparam logic [6:0] RELOAD_A = 7'(TICK_X2_CYCLES / 2 - 1);
  localparam logic [6:0] RELOAD_B = 7'(TICK_X2_CYCLES - TICK_X2_CYCLES / 2 - 1);
  localparam logic [4:0] TEN_LAST = 5'(`VSS_HALF_PER_TEN - 1);

  // linear step period in half microseconds at multiplier 00
  function automatic logic [11:0] lin_half_us(input logic [4:0] sel);
    case (sel)
      5'h00: lin_half_us = 12'd162;
      5'h01: lin_half_us = 12'd158;
      5'h02: lin_half_us = 12'd155;
      5'h03: lin_half_us = 12'd152;
      5'h04: lin_half_us = 12'd149;
      5'h05: lin_half_us = 12'd146;
      5'h06: lin_half_us = 12'd143;
      5'h07: lin_half_us = 12'd140;
      5'h08: lin_half_us = 12'd138;
      5'h09: lin_half_us = 12'd136;
      5'h0A: lin_half_us = 12'd134;
      5'h0B: lin_half_us = 12'd132;
      5'h0C: lin_half_us = 12'd131;
      5'h0D: lin_half_us = 12'd130;
      5'h0E: lin_half_us = 12'd129;
      5'h0F: lin_half_us = 12'd128;
      5'h10: lin_half_us = 12'd272;
      5'h11: lin_half_us = 12'd260;
      5'h12: lin_half_us = 12'd250;
      5'h13: lin_half_us = 12'd240;
      5'h14: lin_half_us = 12'd232;
      5'h15: lin_half_us = 12'd224;
      5'h16: lin_half_us = 12'd216;
      5'h17: lin_half_us = 12'd208;
      5'h18: lin_half_us = 12'd202;
      5'h19: lin_half_us = 12'd196;
      5'h1A: lin_half_us = 12'd190;
      5'h1B: lin_half_us = 12'd184;
      5'h1C: lin_half_us = 12'd178;
      5'h1D: lin_half_us = 12'd174;
      5'h1E: lin_half_us = 12'd170;
      default: lin_half_us = 12'd166;
    endcase
  endfunction

  // two step / enhanced period in ten microseconds at multiplier 00
  function automatic logic [11:0] mode_ten_us(input logic [4:0] sel);
    case (sel)
      5'h00: mode_ten_us = 12'd1266;
      5'h01: mode_ten_us = 12'd1234;
      5'h02: mode_ten_us = 12'd1211;
      5'h03: mode_ten_us = 12'd1188;
      5'h04: mode_ten_us = 12'd1164;
      5'h05: mode_ten_us = 12'd1141;
      5'h06: mode_ten_us = 12'd1117;
      5'h07: mode_ten_us = 12'd1094;
      5'h08: mode_ten_us = 12'd1078;
      5'h09: mode_ten_us = 12'd1063;
      5'h0A: mode_ten_us = 12'd1047;
      5'h0B: mode_ten_us = 12'd1031;
      5'h0C: mode_ten_us = 12'd1023;
      5'h0D: mode_ten_us = 12'd1016;
      5'h0E: mode_ten_us = 12'd1008;
      5'h0F: mode_ten_us = 12'd1000;
      5'h10: mode_ten_us = 12'd2125;
      5'h11: mode_ten_us = 12'd2031;
      5'h12: mode_ten_us = 12'd1953;
      5'h13: mode_ten_us = 12'd1875;
      5'h14: mode_ten_us = 12'd1813;
      5'h15: mode_ten_us = 12'd1750;
      5'h16: mode_ten_us = 12'd1688;
      5'h17: mode_ten_us = 12'd1625;
      5'h18: mode_ten_us = 12'd1578;
      5'h19: mode_ten_us = 12'd1531;
      5'h1A: mode_ten_us = 12'd1484;
      5'h1B: mode_ten_us = 12'd1438;
      5'h1C: mode_ten_us = 12'd1391;
      5'h1D: mode_ten_us = 12'd1359;
      5'h1E: mode_ten_us = 12'd1328;
      default: mode_ten_us = 12'd1297;
    endcase
  endfunction

  // point q quarters of the way from a to b
  function automatic logic [9:0] interp(input logic [9:0] a, input logic [9:0] b,
    input logic [2:0] q);
    logic [12:0] m;
    if (b >= a) begin
      m = {3'b0, b - a} * {10'b0, q};
      interp = a + m[11:2];
    end else begin
      m = {3'b0, a - b} * {10'b0, q};
      interp = a - m[11:2];
    end
  endfunction

  function automatic logic [16:0] code_to_ua(input logic [9:0] c);
    logic [26:0] p;
    p = {17'b0, c} * {10'b0, `VSS_FULL_SCALE_UA};
    code_to_ua = 17'(p / `VSS_CODE_MAX);
  endfunction

  vss_state_t state_reg, state_next;
  vss_kind_t kind_reg, kind_next;
  logic [6:0] pre_reg, pre_next;
  logic half_phase_reg, half_phase_next;
  logic [4:0] ten_reg, ten_next;
  logic [11:0] per_reg, per_next;
  logic [1:0] phase_reg, phase_next;
  logic [9:0] code_reg, code_next;
  logic [9:0] start_reg, start_next;
  logic [9:0] target_reg, target_next;
  logic [1:0] cps_reg, cps_next;
  logic [4:0] step_time_code_reg, step_time_code_next;
  logic [1:0] lin_mult_reg, lin_mult_next;
  logic [1:0] mode_mult_reg, mode_mult_next;
  logic two_step_enable_reg, two_step_enable_next;
  logic enhanced_slope_enable_reg, enhanced_slope_enable_next;
  logic unlock_reg, unlock_next;
  logic ready_reg;
  logic busy_reg, busy_next;
  logic [16:0] ua_reg, ua_next;

  logic half_tick, ten_tick, tick, acc, expire;
  logic [9:0] new_target, stepped;
  logic [11:0] lin_period, mode_period;
  logic [2:0] q;

  always_comb begin
    half_tick = (pre_reg == 7'h00);
    ten_tick = half_tick && (ten_reg == TEN_LAST);
    tick = (kind_reg == VSS_LINEAR) ? half_tick : ten_tick;
    expire = (state_reg == VSS_MOVE) && tick && (per_reg == 12'h001);
    acc = link.wr_valid && ready_reg;
    new_target = {link.wr_b1[5:0], link.wr_b2[7:4]};
    lin_period = lin_half_us(step_time_code_reg) << lin_mult_reg;
    mode_period = mode_ten_us(step_time_code_reg) >> mode_mult_reg;
    stepped = code_reg;
    if (target_reg > code_reg) begin
      stepped = ((target_reg - code_reg) > (10'h001 << (cps_reg - 2'h1))) ?
        code_reg + (10'h001 << (cps_reg - 2'h1)) : target_reg;
    end else if (target_reg < code_reg) begin
      stepped = ((code_reg - target_reg) > (10'h001 << (cps_reg - 2'h1))) ?
        code_reg - (10'h001 << (cps_reg - 2'h1)) : target_reg;
    end
    // two step: half way now, target after one period; enhanced: 1/4, 3/4, target
    q = 3'h4;
    if (kind_reg == VSS_ENH) begin
      q = (phase_reg == 2'h1) ? 3'h3 : 3'h4;
    end

    pre_next = pre_reg - 7'h01;
    half_phase_next = half_phase_reg;
    ten_next = ten_reg;
    if (half_tick) begin
      // alternate reloads so two ticks span exactly the cycle count
      pre_next = half_phase_reg ? RELOAD_A : RELOAD_B;
      half_phase_next = ~half_phase_reg;
      ten_next = ten_tick ? 5'h00 : ten_reg + 5'h01;
    end

    state_next = state_reg;
    kind_next = kind_reg;
    per_next = per_reg;
    phase_next = phase_reg;
    code_next = code_reg;
    start_next = start_reg;
    target_next = target_reg;
    cps_next = cps_reg;
    step_time_code_next = step_time_code_reg;
    lin_mult_next = lin_mult_reg;
    mode_mult_next = mode_mult_reg;
    two_step_enable_next = two_step_enable_reg;
    enhanced_slope_enable_next = enhanced_slope_enable_reg;
    unlock_next = unlock_reg;

    if (acc && link.wr_cmd) begin
      case (link.wr_b1)
        `VSS_UNLOCK_CMD: begin
          if (link.wr_b2 == `VSS_UNLOCK_KEY) begin
            unlock_next = 1'b1;
          end
        end
        `VSS_RELOCK_CMD: begin
          if (link.wr_b2 == `VSS_RELOCK_KEY) begin
            unlock_next = 1'b0;
          end
        end
        `VSS_MODE_CMD: begin
          if (unlock_reg) begin
            enhanced_slope_enable_next = link.wr_b2[`VSS_MODE_ENH_BIT];
            two_step_enable_next = link.wr_b2[`VSS_MODE_TWO_BIT];
            // one multiplier field serves whichever family the bits select
            if (link.wr_b2[`VSS_MODE_ENH_BIT] || link.wr_b2[`VSS_MODE_TWO_BIT]) begin
              mode_mult_next = link.wr_b2[1:0];
            end else begin
              lin_mult_next = link.wr_b2[1:0];
            end
          end
        end
        `VSS_STEP_CMD: begin
          if (unlock_reg) begin
            step_time_code_next = link.wr_b2[7:`VSS_STEP_LSB];
          end
        end
        default: begin
        end
      endcase
    end else if (acc) begin
      // a new target restarts any move from the present code
      target_next = new_target;
      cps_next = link.wr_b2[3:2];
      start_next = code_reg;
      phase_next = 2'h1;
      state_next = (new_target == code_reg) ? VSS_IDLE : VSS_MOVE;
      if (two_step_enable_reg) begin
        kind_next = VSS_TWO;
        per_next = mode_period;
        code_next = interp(code_reg, new_target, 3'h2);
      end else if (enhanced_slope_enable_reg) begin
        kind_next = VSS_ENH;
        per_next = mode_period;
        code_next = interp(code_reg, new_target, 3'h1);
      end else if (link.wr_b2[3:2] == 2'h0) begin
        kind_next = VSS_LINEAR;
        code_next = new_target;
        state_next = VSS_IDLE;
      end else begin
        kind_next = VSS_LINEAR;
        per_next = lin_period;
      end
    end else if (expire) begin
      per_next = (kind_reg == VSS_LINEAR) ? lin_period : mode_period;
      if (kind_reg == VSS_LINEAR) begin
        code_next = stepped;
        state_next = (stepped == target_reg) ? VSS_IDLE : VSS_MOVE;
      end else begin
        code_next = interp(start_reg, target_reg, q);
        phase_next = phase_reg + 2'h1;
        state_next = (q == 3'h4) ? VSS_IDLE : VSS_MOVE;
      end
    end else if ((state_reg == VSS_MOVE) && tick) begin
      per_next = per_reg - 12'h001;
    end

    busy_next = (state_next == VSS_MOVE);
    ua_next = code_to_ua(code_next);
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_reg <= VSS_IDLE;
      kind_reg <= VSS_LINEAR;
      pre_reg <= 7'h00;
      half_phase_reg <= 1'b0;
      ten_reg <= 5'h00;
      per_reg <= 12'h000;
      phase_reg <= 2'h0;
      code_reg <= 10'h000;
      start_reg <= 10'h000;
      target_reg <= 10'h000;
      cps_reg <= 2'h0;
      step_time_code_reg <= `VSS_STEP_TIME_RESET;
      lin_mult_reg <= `VSS_LIN_MULT_RESET;
      mode_mult_reg <= `VSS_MODE_MULT_RESET;
      two_step_enable_reg <= 1'b0;
      enhanced_slope_enable_reg <= 1'b0;
      unlock_reg <= 1'b0;
      ready_reg <= 1'b0;
      busy_reg <= 1'b0;
      ua_reg <= 17'h0_0000;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      pre_reg <= pre_next;
      half_phase_reg <= half_phase_next;
      ten_reg <= ten_next;
      per_reg <= per_next;
      phase_reg <= phase_next;
      code_reg <= code_next;
      start_reg <= start_next;
      target_reg <= target_next;
      cps_reg <= cps_next;
      step_time_code_reg <= step_time_code_next;
      lin_mult_reg <= lin_mult_next;
      mode_mult_reg <= mode_mult_next;
      two_step_enable_reg <= two_step_enable_next;
      enhanced_slope_enable_reg <= enhanced_slope_enable_next;
      unlock_reg <= unlock_next;
      ready_reg <= 1'b1;
      busy_reg <= busy_next;
      ua_reg <= ua_next;
    end
  end

  assign link.wr_ready = ready_reg;
  assign link.busy = busy_reg;
  assign link.code = code_reg;
  assign sink_code_o = code_reg;
  assign sink_current_ua_o = ua_reg;
  assign busy_o = busy_reg;

endmodule

// >>> shared/vss_params.svh
// Purpose: constants shared by both ends of the slope step link
// Assumes: 125 MHz system clock
// Notes: command keys are byte pairs sent as one link transfer
`ifndef VSS_PARAMS_SVH
`define VSS_PARAMS_SVH

`define VSS_CLK_NS 8
`define VSS_HALF_US_NS 500
`define VSS_TEN_US_NS 10000
`define VSS_TICK_X2_CYCLES ((2 * `VSS_HALF_US_NS) / `VSS_CLK_NS)
`define VSS_HALF_PER_TEN (`VSS_TEN_US_NS / `VSS_HALF_US_NS)

`define VSS_UNLOCK_CMD 8'hEC
`define VSS_UNLOCK_KEY 8'hA3
`define VSS_MODE_CMD 8'hA1
`define VSS_STEP_CMD 8'hF2
`define VSS_RELOCK_CMD 8'hDC
`define VSS_RELOCK_KEY 8'h51

`define VSS_MODE_ENH_BIT 4
`define VSS_MODE_TWO_BIT 3
`define VSS_MODE_ONE_BIT 2
`define VSS_STEP_LSB 3

`define VSS_STEP_TIME_RESET 5'h00
`define VSS_LIN_MULT_RESET 2'h1
`define VSS_MODE_MULT_RESET 2'h1

`define VSS_FULL_SCALE_UA 17'd120000
`define VSS_CODE_MAX 27'd1023

`define VSS_REG_TARGET 4'h0
`define VSS_REG_RAW 4'h4
`define VSS_REG_CONFIG 4'h8
`define VSS_REG_STATUS 4'hC
`define VSS_KIND_TWO 2'h1
`define VSS_KIND_ENH 2'h2

`endif

// >>> shared/vss_pkg.sv
// Purpose: types for the slope step controller and its host bridge
// Assumes: nothing
// Notes: encodings left to the tools
package vss_pkg;
  typedef enum logic {VSS_IDLE, VSS_MOVE} vss_state_t;
  typedef enum logic [1:0] {VSS_LINEAR, VSS_TWO, VSS_ENH} vss_kind_t;
  typedef enum logic [1:0] {VSS_H_IDLE, VSS_H_SEND, VSS_H_DONE} vss_host_state_t;
endpackage

// >>> shared/vss_link_if.sv
// Purpose: byte pair link between host bridge and slope controller
// Assumes: one clock for both ends
// Notes: a pair moves on a rising edge with wr_valid and wr_ready both high
`timescale 1ns/1ps
interface vss_link_if;
  logic wr_valid;
  logic wr_cmd;
  logic [7:0] wr_b1;
  logic [7:0] wr_b2;
  logic wr_ready;
  logic busy;
  logic [9:0] code;
  modport dev (input wr_valid, input wr_cmd, input wr_b1, input wr_b2,
    output wr_ready, output busy, output code);
  modport host (output wr_valid, output wr_cmd, output wr_b1, output wr_b2,
    input wr_ready, input busy, input code);
endinterface

// >>> logic/vss_host.sv
// Purpose: Avalon-MM bridge that drives the slope controller link
// Assumes: master holds each request until waitrequest is seen low
// Notes: a config write sends the whole unlock, mode, step, relock sequence
`timescale 1ns/1ps
`include "vss_params.svh"

module vss_host
  import vss_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  vss_link_if.host link
);

  // the four pairs of a configuration sequence, in order
  function automatic logic [15:0] seq_pair(input logic [1:0] idx, input logic [7:0] mode,
    input logic [7:0] step_byte);
    case (idx)
      2'h0: seq_pair = {`VSS_UNLOCK_CMD, `VSS_UNLOCK_KEY};
      2'h1: seq_pair = {`VSS_MODE_CMD, mode};
      2'h2: seq_pair = {`VSS_STEP_CMD, step_byte};
      default: seq_pair = {`VSS_RELOCK_CMD, `VSS_RELOCK_KEY};
    endcase
  endfunction

  vss_host_state_t state_reg, state_next;
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic valid_reg, valid_next;
  logic cmd_reg, cmd_next;
  logic [7:0] b1_reg, b1_next;
  logic [7:0] b2_reg, b2_next;
  logic macro_reg, macro_next;
  logic [1:0] seq_reg, seq_next;
  logic [7:0] mode_reg, mode_next;
  logic [7:0] step_byte_reg, step_byte_next;
  logic [11:0] target_reg, target_next;
  logic stat_busy_reg;
  logic [9:0] stat_code_reg;
  logic [7:0] mode_byte;
  logic [15:0] pair;

  always_comb begin
    // normal ramps send both mode bits clear
    mode_byte = 8'h00;
    mode_byte[`VSS_MODE_ONE_BIT] = 1'b1;
    mode_byte[1:0] = avs_writedata_i[1:0];
    mode_byte[`VSS_MODE_TWO_BIT] = (avs_writedata_i[3:2] == `VSS_KIND_TWO);
    mode_byte[`VSS_MODE_ENH_BIT] = (avs_writedata_i[3:2] == `VSS_KIND_ENH);
    pair = seq_pair(seq_reg + 2'h1, mode_reg, step_byte_reg);

    state_next = state_reg;
    wait_next = wait_reg;
    rdata_next = rdata_reg;
    valid_next = valid_reg;
    cmd_next = cmd_reg;
    b1_next = b1_reg;
    b2_next = b2_reg;
    macro_next = macro_reg;
    seq_next = seq_reg;
    mode_next = mode_reg;
    step_byte_next = step_byte_reg;
    target_next = target_reg;

    case (state_reg)
      VSS_H_IDLE: begin
        if (avs_read_i) begin
          rdata_next = 32'h0000_0000;
          if (avs_address_i == `VSS_REG_STATUS) begin
            rdata_next = {6'h00, stat_code_reg, 15'h0000, stat_busy_reg};
          end else if (avs_address_i == `VSS_REG_TARGET) begin
            rdata_next = {20'h0_0000, target_reg};
          end
          wait_next = 1'b0;
          state_next = VSS_H_DONE;
        end else if (avs_write_i) begin
          state_next = VSS_H_SEND;
          valid_next = 1'b1;
          macro_next = 1'b0;
          case (avs_address_i)
            `VSS_REG_TARGET: begin
              target_next = avs_writedata_i[11:0];
              cmd_next = 1'b0;
              b1_next = {2'h0, avs_writedata_i[9:4]};
              b2_next = {avs_writedata_i[3:0], avs_writedata_i[11:10], 2'h0};
            end
            `VSS_REG_RAW: begin
              cmd_next = 1'b1;
              b1_next = avs_writedata_i[7:0];
              b2_next = avs_writedata_i[15:8];
            end
            `VSS_REG_CONFIG: begin
              // step time passed through as given; tuning it is software's job
              mode_next = mode_byte;
              step_byte_next = {avs_writedata_i[12:8], 3'h0};
              macro_next = 1'b1;
              seq_next = 2'h0;
              cmd_next = 1'b1;
              b1_next = `VSS_UNLOCK_CMD;
              b2_next = `VSS_UNLOCK_KEY;
            end
            default: begin
              valid_next = 1'b0;
              wait_next = 1'b0;
              state_next = VSS_H_DONE;
            end
          endcase
        end
      end
      VSS_H_SEND: begin
        if (valid_reg && link.wr_ready) begin
          if (macro_reg && (seq_reg != 2'h3)) begin
            seq_next = seq_reg + 2'h1;
            b1_next = pair[15:8];
            b2_next = pair[7:0];
          end else begin
            valid_next = 1'b0;
            wait_next = 1'b0;
            state_next = VSS_H_DONE;
          end
        end
      end
      VSS_H_DONE: begin
        wait_next = 1'b1;
        state_next = VSS_H_IDLE;
      end
      default: begin
        state_next = VSS_H_IDLE;
        wait_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_reg <= VSS_H_IDLE;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      valid_reg <= 1'b0;
      cmd_reg <= 1'b0;
      b1_reg <= 8'h00;
      b2_reg <= 8'h00;
      macro_reg <= 1'b0;
      seq_reg <= 2'h0;
      mode_reg <= 8'h00;
      step_byte_reg <= 8'h00;
      target_reg <= 12'h000;
      stat_busy_reg <= 1'b0;
      stat_code_reg <= 10'h000;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      valid_reg <= valid_next;
      cmd_reg <= cmd_next;
      b1_reg <= b1_next;
      b2_reg <= b2_next;
      macro_reg <= macro_next;
      seq_reg <= seq_next;
      mode_reg <= mode_next;
      step_byte_reg <= step_byte_next;
      target_reg <= target_next;
      stat_busy_reg <= link.busy;
      stat_code_reg <= link.code;
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign link.wr_valid = valid_reg;
  assign link.wr_cmd = cmd_reg;
  assign link.wr_b1 = b1_reg;
  assign link.wr_b2 = b2_reg;

endmodule

// >>> sim/vss_link_chk.sv
// Purpose: link and motion checks for the slope controller
// Assumes: one clock, synchronous active high reset
// Notes: helper follows lock state and mode bits seen on the link
`timescale 1ns/1ps
`include "vss_params.svh"
module vss_link_chk (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic wr_valid,
  input wire logic wr_cmd,
  input wire logic [7:0] wr_b1,
  input wire logic [7:0] wr_b2,
  input wire logic wr_ready,
  input wire logic busy,
  input wire logic [9:0] code
);
  logic unl_reg, two_on_reg, enh_on_reg, lin_reg;
  logic [9:0] tgt_reg;
  logic [2:0] step_reg;
  wire take = wr_valid && wr_ready;
  wire [9:0] tgt = {wr_b1[5:0], wr_b2[7:4]};
  wire [1:0] cps = wr_b2[3:2];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      {unl_reg, two_on_reg, enh_on_reg, lin_reg} <= 4'h0;
      tgt_reg <= 10'h000;
      step_reg <= 3'h0;
    end else if (take && !wr_cmd) begin
      tgt_reg <= tgt;
      lin_reg <= !two_on_reg && !enh_on_reg && cps != 2'h0;
      step_reg <= (cps == 2'h3) ? 3'h4 : {1'b0, cps};
    end else if (take && {wr_b1, wr_b2} == {`VSS_UNLOCK_CMD, `VSS_UNLOCK_KEY}) begin
      unl_reg <= 1'b1;
    end else if (take && {wr_b1, wr_b2} == {`VSS_RELOCK_CMD, `VSS_RELOCK_KEY}) begin
      unl_reg <= 1'b0;
    end else if (take && unl_reg && wr_b1 == `VSS_MODE_CMD) begin
      two_on_reg <= wr_b2[`VSS_MODE_TWO_BIT];
      enh_on_reg <= wr_b2[`VSS_MODE_ENH_BIT];
    end
  end
  sequence s_take;
    take && !wr_cmd;
  endsequence
  sequence s_hold8;
    (busy && $stable(code))[*8];
  endsequence
  property p_rst_clear;
    $fell(reset_i) |-> code == 10'h000 && !busy && !wr_ready;
  endproperty
  property p_one_step;
    s_take ##0 (!two_on_reg && !enh_on_reg && cps == 2'h0) |=> code == $past(tgt) && !busy;
  endproperty
  property p_two_first;
    s_take ##0 (two_on_reg && !enh_on_reg && tgt > code)
      |=> busy && code == $past(code) + (($past(tgt) - $past(code)) >> 1);
  endproperty
  property p_both_first;
    s_take ##0 (two_on_reg && enh_on_reg && tgt > code)
      |=> busy && code == $past(code) + (($past(tgt) - $past(code)) >> 1);
  endproperty
  property p_enh_first;
    s_take ##0 (enh_on_reg && !two_on_reg && tgt > code)
      |=> busy && code == $past(code) + (($past(tgt) - $past(code)) >> 2);
  endproperty
  property p_lin_hold;
    s_take ##0 (!two_on_reg && !enh_on_reg && cps != 2'h0 && tgt != code) |=> s_hold8;
  endproperty
  property p_lin_size;
    lin_reg && $changed(code) |-> code == tgt_reg || code == $past(code) + step_reg
      || code == $past(code) - step_reg;
  endproperty
  property p_busy_settle;
    $fell(busy) |-> code == tgt_reg;
  endproperty
  property p_same_target;
    s_take ##0 (tgt == code) |=> !busy && $stable(code);
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset left state");
  a_one_step: assert property (p_one_step) else $error("jump missed target");
  a_two_first: assert property (p_two_first) else $error("two step point wrong");
  a_both_first: assert property (p_both_first) else $error("priority wrong");
  a_enh_first: assert property (p_enh_first) else $error("enhanced point wrong");
  a_lin_hold: assert property (p_lin_hold) else $error("ramp moved early");
  a_lin_size: assert property (p_lin_size) else $error("ramp step size wrong");
  a_busy_settle: assert property (p_busy_settle) else $error("idle off target");
  a_same_target: assert property (p_same_target) else $error("moved on no change");
endmodule

// >>> sim/test_vcm_slope_step_controller.sv
// Purpose: self-checking bench for the slope controller and its bridge
// Assumes: tick parameter cut to 4, so 0.5us is 2 cycles and 10us is 40
// Notes: motion seen on the device code port, settings sent over the bus
`timescale 1ns/1ps
`include "vss_params.svh"
module test_vcm_slope_step_controller;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic ref_clk, reset, rd, wr, wreq, busy;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [9:0] code;
  logic [16:0] cur;
  int num_errors = 0;
  int num_checks = 0;
  int n;
  vss_link_if link_if ();
  vss_device #(.TICK_X2_CYCLES(4)) vss_device_i (.ref_clk_i(ref_clk), .reset_i(reset),
    .link(link_if.dev), .sink_code_o(code), .sink_current_ua_o(cur), .busy_o(busy));
  vss_host vss_host_i (.ref_clk_i(ref_clk), .reset_i(reset), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .link(link_if.host));
  vss_link_chk vss_link_chk_i (.ref_clk_i(ref_clk), .reset_i(reset),
    .wr_valid(link_if.wr_valid), .wr_cmd(link_if.wr_cmd), .wr_b1(link_if.wr_b1),
    .wr_b2(link_if.wr_b2), .wr_ready(link_if.wr_ready), .busy(link_if.busy),
    .code(link_if.code));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one request, held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge ref_clk);
    end while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic tgt(input logic [9:0] t, input logic [1:0] s);
    bus(1'b1, `VSS_REG_TARGET, {20'h0_0000, s, t});
  endtask
  task automatic cfg(input logic [4:0] per_sel, input logic [1:0] kind, input logic [1:0] m);
    bus(1'b1, `VSS_REG_CONFIG, {19'h0_0000, per_sel, 4'h0, kind, m});
  endtask
  task automatic raw(input logic [7:0] b1, input logic [7:0] b2);
    bus(1'b1, `VSS_REG_RAW, {16'h0000, b2, b1});
  endtask
  task automatic step_wait();
    logic [9:0] c;
    c = code;
    n = 0;
    while (code === c) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic t_reset();
    bus(1'b0, `VSS_REG_STATUS, ZERO);
    check(q, ZERO);
    bus(1'b0, 4'h2, ZERO);
    check(q, ZERO);
    check(cur, 17'h0_0000);
  endtask
  task automatic t_one();
    tgt(10'h3FF, 2'h0);
    check(cur, 17'h1_D4C0);
    tgt(10'h200, 2'h0);
    check(cur, 17'h0_EA9A);
    tgt(10'h200, 2'h1);
    tgt(10'h064, 2'h0);
    bus(1'b0, `VSS_REG_STATUS, ZERO);
    check(q, 32'h0064_0000);
    bus(1'b0, `VSS_REG_TARGET, ZERO);
    check(q, 32'h0000_0064);
  endtask
  task automatic t_linear();
    tgt(10'h067, 2'h1);
    step_wait();
    step_wait();
    check(n, 648);
    step_wait();
    check(n, 648);
    check(code, 10'h067);
    repeat (2) @(posedge ref_clk);
    check(busy, 1'b0);
    cfg(5'h0F, 2'h0, 2'h0);
    tgt(10'h06D, 2'h3);
    step_wait();
    check(code, 10'h06B);
    step_wait();
    check(n, 256);
    check(code, 10'h06D);
    cfg(5'h0F, 2'h0, 2'h2);
    tgt(10'h070, 2'h2);
    step_wait();
    check(code, 10'h06F);
    step_wait();
    check(n, 1024);
    check(code, 10'h070);
  endtask
  task automatic t_enh();
    cfg(5'h00, 2'h2, 2'h3);
    tgt(10'h1FD, 2'h0);
    step_wait();
    check(code, 10'h199);
    step_wait();
    check(n, 6320);
    check(code, 10'h1FD);
  endtask
  task automatic t_two();
    cfg(5'h00, 2'h1, 2'h3);
    tgt(10'h38D, 2'h0);
    step_wait();
    check(n >= 6280 && n <= 6320, 1'b1);
    check(code, 10'h38D);
  endtask
  task automatic t_lock();
    raw(`VSS_UNLOCK_CMD, `VSS_UNLOCK_KEY);
    raw(`VSS_MODE_CMD, 8'h1F);
    raw(`VSS_STEP_CMD, 8'h00);
    raw(`VSS_RELOCK_CMD, `VSS_RELOCK_KEY);
    // a mode write while locked must not drop back to plain jumps
    raw(`VSS_MODE_CMD, 8'h04);
    tgt(10'h3F1, 2'h0);
    check(code, 10'h3BF);
    step_wait();
    check(code, 10'h3F1);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (50000) @(posedge ref_clk);
    num_errors++;
    complete_run();
  end
  initial begin
    reset = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    wdata = ZERO;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_one();
    t_linear();
    t_enh();
    t_two();
    t_lock();
    complete_run();
  end
endmodule
